// *** tb/dpdt_pin_src.sv ***
/* source on the timer 1 pin.
   assumes en changes just after pclk edges. */
`timescale 1ns/1ns
// ----
// pin source
// ----
module dpdt_pin_src (
   // clock and request
   input wire pclk,
   input wire en,
   // pin
   output reg pin
);
   // toggles while enabled; rests low, as a pulled-down pin would
   initial pin = 1'b0;
   always @(posedge pclk) begin
      pin <= en ? ~pin : 1'b0;
   end
endmodule

// *** tb/dpdt_props.sv ***
/* port assertions for dpdt_top.
   assumes the bind below and byte addresses D2h..D7h times four. */
`timescale 1ns/1ns
// ----
// checker
// ----
module dpdt_props (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [9:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pslverr,
   // pin and requests
   input wire timer_pin_oe,
   input wire timer1_irq,
   input wire timer2_irq
);
   // access strobes; c1/c2 are control writes of timer 1 and 2
   wire acc = psel && penable;
   wire c1 = acc && pwrite && paddr == 10'h350;
   wire c2 = acc && pwrite && paddr == 10'h35C;
   wire bad = acc && (paddr[9:2] < 8'hD2 || paddr[9:2] > 8'hD7);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_unmapped_err: assert property (bad |-> pslverr && prdata == 32'h0)
      else $error("unmapped access");
   chk_mapped_ok: assert property (acc && !bad |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("mapped access");
   chk_psc_msb: assert property (acc && paddr[9:2] inside {8'hD2, 8'hD5} |-> !prdata[7])
      else $error("prescaler bit 7");
   chk_reset_quiet: assert property ($rose(presetn) |-> !timer1_irq && !timer2_irq)
      else $error("reset state");
   chk_oe_follows: assert property (c1 |=> timer_pin_oe == $past(pwdata[5]))
      else $error("pin enable");
   chk_flag_irq: assert property (c1 && pwdata[7:6] == 2'b11 |=> timer1_irq)
      else $error("flag write");
   chk_irq_mask: assert property (c1 && !pwdata[6] |=> !timer1_irq)
      else $error("irq mask");
   chk_irq2_mask: assert property (c2 && !pwdata[6] |=> !timer2_irq[*2])
      else $error("irq2 mask");
   chk_flag_sticky: assert property ($fell(timer1_irq) |-> $past(c1))
      else $error("flag cleared");
endmodule

bind dpdt_top dpdt_props dpdt_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .timer_pin_oe(timer_pin_oe), .timer1_irq(timer1_irq),
   .timer2_irq(timer2_irq));

// *** tb/dual_prescaled_down_timer_tb.sv ***
/* bench for dpdt_top: apb master, pin source, scenarios.
   assumes pready answers within the timeout. */
`timescale 1ns/1ns
// ----
// bench
// ----
module dual_prescaled_down_timer_tb;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg en = 1'b0;
   reg [9:0] paddr = 10'h0;
   reg [31:0] pwdata = 32'h0;
   reg [31:0] rd = 32'h0;
   reg err = 1'b0;
   wire pready, pslverr, pin_out, pin_oe, irq1, irq2, src_pin;
   wire [31:0] prdata;
   integer miscompares = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   always #5 pclk = ~pclk;
   dpdt_top dpdt_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .timer_pin_in(pin_oe ? pin_out : src_pin), .timer_pin_out(pin_out),
      .timer_pin_oe(pin_oe), .timer1_irq(irq1), .timer2_irq(irq2));
   dpdt_pin_src dpdt_pin_src_i (.pclk(pclk), .en(en), .pin(src_pin));
   // cycle cap; the scenarios need far fewer cycles
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         miscompares = miscompares + 1;
         end_sim;
      end
   end
   task apb(input [9:0] a, input w, input [7:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         paddr <= a;
         pwrite <= w;
         pwdata <= {24'h0, d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         // taken at the answering edge, before that edge's updates land
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         // let the write settle before the caller looks at outputs
         @(negedge pclk);
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("Error %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task rdchk(input [9:0] a, input [7:0] e);
      begin
         apb(a, 1'b0, 8'h0);
         chk(rd, {24'h0, e});
      end
   endtask
   task t_reset;
      integer i;
      begin
         for (i = 0; i < 6; i = i + 1)
            rdchk(10'h348 + 4 * i, (i % 3 == 0) ? 8'h7F : (i % 3 == 1) ? 8'hFF : 8'h00);
         apb(10'h3FC, 1'b0, 8'h0);
         chk({31'h0, err}, 32'h1);
         apb(10'h348, 1'b1, 8'h10);
         rdchk(10'h348, 8'h7F);
         $display("t_reset done");
      end
   endtask
   task t_flag;
      begin
         apb(10'h350, 1'b1, 8'hC0);
         rdchk(10'h350, 8'hC0);
         chk({31'h0, irq1}, 32'h1);
         apb(10'h350, 1'b1, 8'h00);
         chk({31'h0, irq1}, 32'h0);
         apb(10'h358, 1'b1, 8'h00);
         rdchk(10'h35C, 8'h80);
         $display("t_flag done");
      end
   endtask
   task t_count;
      integer n;
      begin
         n = 0;
         apb(10'h35C, 1'b1, 8'h48);
         apb(10'h358, 1'b1, 8'h02);
         while (irq2 !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n = n + 1;
         end
         chk({31'h0, irq2}, 32'h1);
         chk({31'h0, n > 11}, 32'h1);
         apb(10'h35C, 1'b1, 8'h00);
         chk({31'h0, irq2}, 32'h0);
         $display("t_count done");
      end
   endtask
   task t_event;
      begin
         apb(10'h34C, 1'b1, 8'h03);
         apb(10'h350, 1'b1, 8'h08);
         @(posedge pclk);
         en <= 1'b1;
         repeat (6) @(posedge pclk);
         en <= 1'b0;
         repeat (3) @(posedge pclk);
         rdchk(10'h34C, 8'h00);
         rdchk(10'h348, 8'h7C);
         rdchk(10'h350, 8'h88);
         $display("t_event done");
      end
   endtask
   task t_output;
      begin
         apb(10'h350, 1'b1, 8'h38);
         chk({30'h0, pin_oe, pin_out}, 32'h2);
         apb(10'h34C, 1'b1, 8'h00);
         repeat (2) @(posedge pclk);
         chk({31'h0, pin_out}, 32'h1);
         $display("t_output done");
      end
   endtask
   task t_gated;
      begin
         apb(10'h350, 1'b1, 8'h10);
         apb(10'h350, 1'b1, 8'h18);
         repeat (30) @(posedge pclk);
         rdchk(10'h348, 8'h7F);
         $display("t_gated done");
      end
   endtask
   task end_sim;
      begin
         $display("compares %0d mismatches %0d", cmp_count, miscompares);
         if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // reset, then the scenarios in order
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_flag;
      t_count;
      t_event;
      t_output;
      t_gated;
      end_sim;
   end
endmodule

// *** verilog/dpdt_map.vh ***
/*
 * register map, field positions, reset values and divider constants of the
 * dual prescaled down timer.
 * assumes byte addresses on a 32-bit apb, one register per aligned word.
 */
`ifndef DPDT_MAP_VH
`define DPDT_MAP_VH

// ----------------------------------------------------------------------
// register indices; the apb byte address is the index times four
// ----------------------------------------------------------------------
`define DPDT_IDX_T1_PRESCALER 8'hD2
`define DPDT_IDX_T1_COUNTER 8'hD3
`define DPDT_IDX_T1_CONTROL 8'hD4
`define DPDT_IDX_T2_PRESCALER 8'hD5
`define DPDT_IDX_T2_COUNTER 8'hD6
`define DPDT_IDX_T2_CONTROL 8'hD7
`define DPDT_ADDR_W 10

// ----------------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------------
`define DPDT_ZERO_FLAG 7
`define DPDT_ZERO_IRQ_EN 6
`define DPDT_PIN_OUT_SEL 5
`define DPDT_PIN_DATA 4
`define DPDT_PRESC_RUN 3
`define DPDT_TAP_HI 2

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define DPDT_CNT_RESET 8'hFF
`define DPDT_PSC_RESET 7'h7F
`define DPDT_CTL_RESET 8'h00
`define DPDT_INT_DIV 12
`define DPDT_DIV_W 4
`define DPDT_DIV_LAST 4'hB

`endif

// *** verilog/dpdt_top.v ***
/*
 * dual prescaled down timer: two 8-bit down counters, each behind a 7-bit
 * down prescaler with a tap select, apb register slave, and the timer 1 pin.
 * assumes pclk is the internal frequency and the pin input is synchronous.
 */
// Chosen here: the register addresses and register access over APB.
// Behaviour
// - two timers, 8-bit counter, 7-bit prescaler
// - counter decrements on tap rise, software rw
// - reaching zero sets zero flag
// - irq when flag and enable both set
// - internal clock divided by twelve, timer1 pin
// - prescaler decrements on input rising edge
// - tap select picks prescaler bit as clock
// - codes 0..7 give factors 1..128
// - run low forces prescaler ones, stops all
// - prescaler loadable 0..7Fh while running
// - gated mode counts only while pin high
// - event mode counts pin rising edges
// - output mode latches pin data on flag rise
// - only timer 1 has pin modes
// - writing 00h or bit7 sets flag
// - reset loads FFh, 7Fh, clears control
// - counter write beats coincident zero reach
// - counter and prescaler read live values
// - control bit layout 7 to 0
`timescale 1ns/1ns
`include "dpdt_map.vh"

// ----------------------------------------------------------------------
// one timer channel
// ----------------------------------------------------------------------
module dpdt_chan #(
   parameter HAS_PIN = 1
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // common divided tick
   input wire tick_int,
   // register writes
   input wire wr_psc,
   input wire wr_cnt,
   input wire wr_ctl,
   input wire [7:0] wdata,
   // timer pin
   input wire pin_in,
   output reg pin_out,
   output wire pin_oe,
   // state
   output reg [7:0] down_counter_value,
   output reg [6:0] prescaler_value,
   output reg [7:0] timer_control_status,
   output wire irq
);
   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   // control fields
   wire zero_flag;
   wire zero_irq_enable;
   wire prescaler_run;
   wire pin_output_select;
   wire pin_data_value;
   wire [2:0] tap_select;
   // pin history and prescaler input
   reg pin_q;
   reg psc_tick;
   // prescaler decrement and the selected tap
   wire [6:0] next_psc;
   reg tap_now;
   reg tap_next;
   wire tap_rise;
   // counter events
   wire cnt_dec;
   wire hit_zero;
   wire sw_zero;
   wire flag_set;
   // output latch
   reg flag_q;
   wire flag_rise;

   // ----------------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------------
   // field split of the control byte
   assign zero_flag = timer_control_status[`DPDT_ZERO_FLAG];
   assign zero_irq_enable = timer_control_status[`DPDT_ZERO_IRQ_EN];
   assign prescaler_run = timer_control_status[`DPDT_PRESC_RUN];
   // timer 2 stores bits 5 and 4 but never acts on them
   assign pin_output_select = (HAS_PIN != 0) && timer_control_status[`DPDT_PIN_OUT_SEL];
   assign pin_data_value = timer_control_status[`DPDT_PIN_DATA];
   assign tap_select = timer_control_status[`DPDT_TAP_HI:0];

   // ----------------------------------------------------------------------
   // prescaler input
   // ----------------------------------------------------------------------
   // the pin is one clock old here; it only marks the edge, which is seen in the cycle the pin rises
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pin_q <= 1'b0; // matches the low idle level, so no false edge after reset
      else
         pin_q <= pin_in;
   end

   // prescaler input select; timer 2 ignores the pin
   always @* begin
      if (HAS_PIN == 0 || pin_output_select)
         psc_tick = tick_int;
      else if (pin_data_value)
         psc_tick = tick_int & pin_in;
      else
         psc_tick = pin_in & ~pin_q;
   end

   // ----------------------------------------------------------------------
   // tap selection
   // ----------------------------------------------------------------------
   // value the prescaler takes on its next tick
   assign next_psc = prescaler_value - 7'h01;

   // the selected bit before and after the tick; the counter clock rises
   // where it goes 0 -> 1, i.e. where the decrement borrows through it.
   // factor 1 has no bit of its own: every prescaler tick counts.
   always @* begin
      tap_now = 1'b0;
      tap_next = 1'b0;
      case (tap_select)
         3'h0: begin
            tap_now = 1'b0;
            tap_next = 1'b1;
         end
         3'h1: begin
            tap_now = prescaler_value[0];
            tap_next = next_psc[0];
         end
         3'h2: begin
            tap_now = prescaler_value[1];
            tap_next = next_psc[1];
         end
         3'h3: begin
            tap_now = prescaler_value[2];
            tap_next = next_psc[2];
         end
         3'h4: begin
            tap_now = prescaler_value[3];
            tap_next = next_psc[3];
         end
         3'h5: begin
            tap_now = prescaler_value[4];
            tap_next = next_psc[4];
         end
         3'h6: begin
            tap_now = prescaler_value[5];
            tap_next = next_psc[5];
         end
         3'h7: begin
            tap_now = prescaler_value[6];
            tap_next = next_psc[6];
         end
         default: begin
            tap_now = 1'b0;
            tap_next = 1'b0;
         end
      endcase
   end

   // counter clock edge
   assign tap_rise = psc_tick & ~tap_now & tap_next;

   // ----------------------------------------------------------------------
   // counter events
   // ----------------------------------------------------------------------
   // a stopped prescaler never clocks the counter
   assign cnt_dec = prescaler_run & tap_rise;
   // a software write beats a coincident reach of zero
   assign hit_zero = cnt_dec & (down_counter_value == 8'h01) & ~wr_cnt;
   // writing 00h to the counter also marks zero
   assign sw_zero = wr_cnt & (wdata == 8'h00);
   assign flag_set = hit_zero | sw_zero;
   // level request, also good as a wake-up
   assign irq = zero_flag & zero_irq_enable;
   assign pin_oe = pin_output_select;

   // ----------------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------------
   // down counter; runs on through zero so periodic use needs no reload
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         down_counter_value <= `DPDT_CNT_RESET;
      end else if (wr_cnt) begin
         down_counter_value <= wdata;
      end else if (cnt_dec) begin
         down_counter_value <= down_counter_value - 8'h01; // wraps 00 -> FF
      end
   end

   // prescaler; held at all ones while stopped, so a write then is lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescaler_value <= `DPDT_PSC_RESET;
      end else if (!prescaler_run) begin
         prescaler_value <= `DPDT_PSC_RESET;
      end else if (wr_psc) begin
         prescaler_value <= wdata[6:0];
      end else if (psc_tick) begin
         prescaler_value <= next_psc;
      end
   end

   // control byte; a hardware set in the cycle of a clearing write wins,
   // so a zero reached during the service routine is never lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_status <= `DPDT_CTL_RESET;
      end else if (wr_ctl) begin
         timer_control_status <= {wdata[7] | flag_set, wdata[6:0]};
      end else if (flag_set) begin
         timer_control_status[`DPDT_ZERO_FLAG] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // output latch
   // ----------------------------------------------------------------------
   // flag history starts low like the flag itself, so reset gives no edge
   assign flag_rise = zero_flag & ~flag_q;

   // pin data latched on the flag's rising edge; a held flag latches once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
         pin_out <= 1'b0;
      end else begin
         flag_q <= zero_flag;
         if (flag_rise && HAS_PIN != 0)
            pin_out <= pin_data_value;
      end
   end
endmodule

// ----------------------------------------------------------------------
// apb slave and the two channels
// ----------------------------------------------------------------------
module dpdt_top (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`DPDT_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // timer 1 pin
   input wire timer_pin_in,
   output wire timer_pin_out,
   output wire timer_pin_oe,
   // interrupt requests, also usable as wait wake-up
   output wire timer1_irq,
   output wire timer2_irq
);
   reg [`DPDT_DIV_W-1:0] div_cnt;
   wire tick_int;
   wire [7:0] idx = paddr[`DPDT_ADDR_W-1:2];
   wire wr = psel & penable & pwrite;
   wire [7:0] cnt1, cnt2, ctl1, ctl2;
   wire [6:0] psc1, psc2;
   reg hit;

   // internal frequency divided by twelve, shared by both timers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         div_cnt <= {`DPDT_DIV_W{1'b0}};
      else if (div_cnt == `DPDT_DIV_LAST)
         div_cnt <= {`DPDT_DIV_W{1'b0}};
      else
         div_cnt <= div_cnt + 4'h1;
   end
   assign tick_int = (div_cnt == `DPDT_DIV_LAST);

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;

   dpdt_chan #(.HAS_PIN(1)) u_t1 (
      .pclk(pclk), .presetn(presetn), .tick_int(tick_int),
      .wr_psc(wr & (idx == `DPDT_IDX_T1_PRESCALER)),
      .wr_cnt(wr & (idx == `DPDT_IDX_T1_COUNTER)),
      .wr_ctl(wr & (idx == `DPDT_IDX_T1_CONTROL)),
      .wdata(pwdata[7:0]), .pin_in(timer_pin_in),
      .pin_out(timer_pin_out), .pin_oe(timer_pin_oe),
      .down_counter_value(cnt1), .prescaler_value(psc1),
      .timer_control_status(ctl1), .irq(timer1_irq)
   );

   dpdt_chan #(.HAS_PIN(0)) u_t2 (
      .pclk(pclk), .presetn(presetn), .tick_int(tick_int),
      .wr_psc(wr & (idx == `DPDT_IDX_T2_PRESCALER)),
      .wr_cnt(wr & (idx == `DPDT_IDX_T2_COUNTER)),
      .wr_ctl(wr & (idx == `DPDT_IDX_T2_CONTROL)),
      .wdata(pwdata[7:0]), .pin_in(1'b0),
      .pin_out(), .pin_oe(),
      .down_counter_value(cnt2), .prescaler_value(psc2),
      .timer_control_status(ctl2), .irq(timer2_irq)
   );

   // live read mux; prescaler bit 7 reads zero
   always @* begin
      hit = 1'b1;
      prdata = 32'h00000000;
      case (idx)
         `DPDT_IDX_T1_PRESCALER: prdata = {25'h0000000, psc1};
         `DPDT_IDX_T1_COUNTER: prdata = {24'h000000, cnt1};
         `DPDT_IDX_T1_CONTROL: prdata = {24'h000000, ctl1};
         `DPDT_IDX_T2_PRESCALER: prdata = {25'h0000000, psc2};
         `DPDT_IDX_T2_COUNTER: prdata = {24'h000000, cnt2};
         `DPDT_IDX_T2_CONTROL: prdata = {24'h000000, ctl2};
         default: hit = 1'b0;
      endcase
   end
endmodule
